// *** src/dual_timer_consts.vh ***
// dual_timer_consts.vh
// constants for the dual timer/counter block: register offsets, fields, timing
// assumes inclusion by bare name from files under src/
`ifndef DUAL_TIMER_CONSTS_VH
`define DUAL_TIMER_CONSTS_VH

// register offsets on the 8-bit special register bus
`define ADDR_CTRL          8'h88
`define ADDR_MODE          8'h89
`define ADDR_T0_LOW        8'h8a
`define ADDR_T1_LOW        8'h8b
`define ADDR_T0_HIGH       8'h8c
`define ADDR_T1_HIGH       8'h8d

// reset values
`define MODE_RESET         8'h00
`define CTRL_RESET         8'h00
`define COUNT_RESET        8'h00

// mode register fields (timer 1 in upper nibble, timer 0 lower)
`define MODE_T1_GATE       7
`define MODE_T1_CNT_SEL    6
`define MODE_T1_MODE_HI    5
`define MODE_T1_MODE_LO    4
`define MODE_T0_GATE       3
`define MODE_T0_CNT_SEL    2
`define MODE_T0_MODE_HI    1
`define MODE_T0_MODE_LO    0

// control register fields
`define CTRL_T1_OVF        7
`define CTRL_T1_RUN        6
`define CTRL_T0_OVF        5
`define CTRL_T0_RUN        4
`define CTRL_IRQ1_FLAG     3
`define CTRL_IRQ1_TRIG     2
`define CTRL_IRQ0_FLAG     1
`define CTRL_IRQ0_TRIG     0

// mode encodings
`define MODE_13BIT         2'h0
`define MODE_16BIT         2'h1
`define MODE_RELOAD        2'h2
`define MODE_SPLIT         2'h3

// prescaler width in mode 0
`define PRESCALE_BITS      5
`define PRESCALE_MAX       5'h1f

// tick divider: oscillator cycles per timer tick
`define TICK_DIV           12
`define TICK_CNT_W         4
`define TICK_LAST          4'hb

`endif

// *** src/pin_sampler.v ***
// pin_sampler.v
// double-flop synchroniser plus tick-rate falling transition detector
// assumes tick_i is a one-cycle pulse from the same clock
`timescale 1ns/1ps

module pin_sampler
(
    input  wire sys_clk_i,
    input  wire rst_n_i,
    input  wire pin_i,
    input  wire tick_i,
    output wire level_o,
    output reg  fall_o
);

    reg meta;
    reg sync;
    reg sample;

    // ----------------------------------------------------------------
    // synchroniser and tick sampler
    // ----------------------------------------------------------------
    // first flop feeds only the second; sample taken once per tick
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta   <= 1'b1;
            sync   <= 1'b1;
            sample <= 1'b1;
            fall_o <= 1'b0;
        end
        else
        begin
            meta <= pin_i;
            sync <= meta;
            if (tick_i)
            begin
                sample <= sync;
                fall_o <= sample & ~sync; // one then zero seen
            end
        end
    end

    assign level_o = sync;

endmodule

// *** src/timer_tick_gen.v ***
// timer_tick_gen.v
// divides the oscillator clock down to the timer tick rate
// assumes sys_clk_i is the oscillator clock
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module timer_tick_gen
(
    input  wire sys_clk_i,
    input  wire rst_n_i,
    output reg  tick_o
);

    reg [`TICK_CNT_W-1:0] div_cnt;

    // ----------------------------------------------------------------
    // free running divider
    // ----------------------------------------------------------------
    // one pulse every twelve clocks, independent of any bus activity
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            div_cnt <= {`TICK_CNT_W{1'b0}};
            tick_o  <= 1'b0;
        end
        else
        begin
            tick_o <= (div_cnt == `TICK_LAST);
            if (div_cnt == `TICK_LAST)
                div_cnt <= {`TICK_CNT_W{1'b0}};
            else
                div_cnt <= div_cnt + 1'b1;
        end
    end

endmodule

// *** src/dual_timer_counter.v ***
// dual_timer_counter.v
// two timer/counters with shared mode and control registers
// assumes a synchronous 8-bit register port and an interrupt
// controller that pulses the service acknowledge inputs
//
// Overview of operation
// - each timer has four modes from its two-bit mode field
// - mode 0: 13-bit count, low five bits prescale by 32
// - mode 0: upper three low-byte bits undefined for software
// - wrap from all ones to zero sets overflow flag
// - count only when run set and gate clear or irq pin high
// - setting run leaves count registers untouched
// - mode 1: full 16-bit cascade, no prescaler
// - mode 2: low byte counts, reloads from high byte on overflow
// - timer 1 mode 3 holds count as if run cleared
// - timer 0 mode 3: low byte uses timer 0 controls
// - timer 0 mode 3: high byte ticks, uses timer 1 run/flag
// - timer 1 keeps counting while timer 0 in mode 3
// - mode register layout gate/select/mode, reset zero
// - select 0 internal tick, select 1 count pin
// - irq pin activity sets its flag independently
// - trigger type bit picks edge or level per pin
// - timer ticks every twelve oscillator cycles
// - count pin sampled per tick; one-then-zero increments next
// - overflow flag cleared by hardware on service
// - trigger 1 falling edge, 0 low level
`timescale 1ns/1ps
`include "dual_timer_consts.vh"

module dual_timer_counter
(
    input  wire       sys_clk_i,
    input  wire       rst_n_i,
    input  wire [7:0] reg_addr_i,
    input  wire [7:0] reg_wdata_i,
    input  wire       reg_wr_i,
    output reg  [7:0] reg_rdata_o,
    input  wire       t0_count_pin_i,
    input  wire       t1_count_pin_i,
    input  wire       ext_irq0_pin_i,
    input  wire       ext_irq1_pin_i,
    input  wire       t0_ack_i,
    input  wire       t1_ack_i,
    input  wire       irq0_ack_i,
    input  wire       irq1_ack_i,
    output wire       t0_overflow_flag_o,
    output wire       t1_overflow_flag_o,
    output wire       ext_irq0_flag_o,
    output wire       ext_irq1_flag_o,
    output reg        t1_overflow_pulse_o
);

    reg  [7:0] timer_mode_register;
    reg  [7:0] t0_count_low;
    reg  [7:0] t0_count_high;
    reg  [7:0] t1_count_low;
    reg  [7:0] t1_count_high;
    reg        t0_run;
    reg        t1_run;
    reg        t0_overflow_flag;
    reg        t1_overflow_flag;
    reg        ext_irq0_flag;
    reg        ext_irq1_flag;
    reg        ext_irq0_trigger_type;
    reg        ext_irq1_trigger_type;
    reg        irq0_last;
    reg        irq1_last;

    wire       tick;
    wire       c0_fall;
    wire       c1_fall;
    wire       irq0_lvl;
    wire       irq1_lvl;
    wire       c0_lvl_unused;
    wire       c1_lvl_unused;
    wire       irq0_fall_unused;
    wire       irq1_fall_unused;

    // ----------------------------------------------------------------
    // tick and pin sampling
    // ----------------------------------------------------------------
    timer_tick_gen u_tick
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .tick_o    (tick)
    );

    pin_sampler u_c0
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (t0_count_pin_i),
        .tick_i    (tick),
        .level_o   (c0_lvl_unused),
        .fall_o    (c0_fall)
    );

    pin_sampler u_c1
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (t1_count_pin_i),
        .tick_i    (tick),
        .level_o   (c1_lvl_unused),
        .fall_o    (c1_fall)
    );

    pin_sampler u_i0
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (ext_irq0_pin_i),
        .tick_i    (tick),
        .level_o   (irq0_lvl),
        .fall_o    (irq0_fall_unused)
    );

    pin_sampler u_i1
    (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (ext_irq1_pin_i),
        .tick_i    (tick),
        .level_o   (irq1_lvl),
        .fall_o    (irq1_fall_unused)
    );

    // ----------------------------------------------------------------
    // count enables
    // ----------------------------------------------------------------
    // two-bit mode field per timer
    wire [1:0] t0_mode = timer_mode_register[`MODE_T0_MODE_HI:`MODE_T0_MODE_LO];
    wire [1:0] t1_mode = timer_mode_register[`MODE_T1_MODE_HI:`MODE_T1_MODE_LO];

    // gated enable and clock source select, computed per timer
    function step;
        input run;
        input gate;
        input irq_lvl;
        input cnt_sel;
        input pin_fall;
        input tk;
        begin
            // fall flag stands a whole tick period, so count it once at the next tick
            step = run & (~gate | irq_lvl) & tk & (~cnt_sel | pin_fall);
        end
    endfunction

    // low byte keeps timer 0 controls
    wire t0_inc = step(t0_run, timer_mode_register[`MODE_T0_GATE], irq0_lvl,
                       timer_mode_register[`MODE_T0_CNT_SEL], c0_fall, tick);
    // mode 3 acts as run cleared
    // timer 1 runs on while timer 0 is split
    wire t1_inc = step(t1_run & (t1_mode != `MODE_SPLIT), timer_mode_register[`MODE_T1_GATE],
                       irq1_lvl, timer_mode_register[`MODE_T1_CNT_SEL], c1_fall, tick);
    // split high byte on tick, timer 1 run
    wire t0_split = (t0_mode == `MODE_SPLIT);
    wire th0_inc  = t0_split & t1_run & tick;

    // ----------------------------------------------------------------
    // counter advance function
    // ----------------------------------------------------------------
    // returns {overflow, next_high, next_low} for modes 0..2 and split low byte
    function [16:0] advance;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        reg   [4:0] pre;
        begin
            pre = lo[`PRESCALE_BITS-1:0];
            case (mode)
                `MODE_13BIT:
                begin
                    // upper low bits left as they are
                    if (pre == `PRESCALE_MAX)
                        advance = {(hi == 8'hff), hi + 8'h01, lo[7:5], 5'h00};
                    else
                        advance = {1'b0, hi, lo[7:5], pre + 5'h01};
                end
                `MODE_16BIT:
                begin
                    advance = {({hi, lo} == 16'hffff), ({hi, lo} + 16'h0001)};
                end
                `MODE_RELOAD:
                begin
                    if (lo == 8'hff)
                        advance = {1'b1, hi, hi};
                    else
                        advance = {1'b0, hi, lo + 8'h01};
                end
                default:
                begin
                    // split: low byte alone, high byte handled apart
                    advance = {(lo == 8'hff), hi, lo + 8'h01};
                end
            endcase
        end
    endfunction

    wire [16:0] t0_next = advance(t0_mode, t0_count_high, t0_count_low);
    wire [16:0] t1_next = advance(t1_mode, t1_count_high, t1_count_low);

    wire t0_ovf  = t0_inc & t0_next[16];
    wire t1_ovf  = t1_inc & t1_next[16];
    wire th0_ovf = th0_inc & (t0_count_high == 8'hff);

    // ----------------------------------------------------------------
    // register writes and counting
    // ----------------------------------------------------------------
    wire wr_mode = reg_wr_i & (reg_addr_i == `ADDR_MODE);
    wire wr_ctrl = reg_wr_i & (reg_addr_i == `ADDR_CTRL);
    wire wr_t0l  = reg_wr_i & (reg_addr_i == `ADDR_T0_LOW);
    wire wr_t0h  = reg_wr_i & (reg_addr_i == `ADDR_T0_HIGH);
    wire wr_t1l  = reg_wr_i & (reg_addr_i == `ADDR_T1_LOW);
    wire wr_t1h  = reg_wr_i & (reg_addr_i == `ADDR_T1_HIGH);

    // count registers: software write wins over a count in the same cycle
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            t0_count_low  <= `COUNT_RESET;
            t0_count_high <= `COUNT_RESET;
            t1_count_low  <= `COUNT_RESET;
            t1_count_high <= `COUNT_RESET;
        end
        else
        begin
            if (wr_t0l)
                t0_count_low <= reg_wdata_i;
            else if (t0_inc)
                t0_count_low <= t0_next[7:0];
            if (wr_t0h)
                t0_count_high <= reg_wdata_i;
            else if (th0_inc)
                t0_count_high <= t0_count_high + 8'h01;
            else if (t0_inc & ~t0_split)
                t0_count_high <= t0_next[15:8];
            if (wr_t1l)
                t1_count_low <= reg_wdata_i;
            else if (t1_inc)
                t1_count_low <= t1_next[7:0];
            if (wr_t1h)
                t1_count_high <= reg_wdata_i;
            else if (t1_inc)
                t1_count_high <= t1_next[15:8];
        end
    end

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            timer_mode_register <= `MODE_RESET;
        else if (wr_mode)
            timer_mode_register <= reg_wdata_i;
    end

    // ----------------------------------------------------------------
    // control register and flags
    // ----------------------------------------------------------------
    // edge or level per pin
    // one is falling edge, zero low level
    wire irq0_hit = ext_irq0_trigger_type ? (irq0_last & ~irq0_lvl) : ~irq0_lvl;
    wire irq1_hit = ext_irq1_trigger_type ? (irq1_last & ~irq1_lvl) : ~irq1_lvl;

    // flags: hardware set beats a same-cycle clear by service; register writes never clear them
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            t0_run                <= 1'b0;
            t1_run                <= 1'b0;
            t0_overflow_flag      <= 1'b0;
            t1_overflow_flag      <= 1'b0;
            ext_irq0_flag         <= 1'b0;
            ext_irq1_flag         <= 1'b0;
            ext_irq0_trigger_type <= 1'b0;
            ext_irq1_trigger_type <= 1'b0;
            irq0_last             <= 1'b1;
            irq1_last             <= 1'b1;
            t1_overflow_pulse_o   <= 1'b0;
        end
        else
        begin
            irq0_last <= irq0_lvl;
            irq1_last <= irq1_lvl;
            if (wr_ctrl)
            begin
                t0_run                <= reg_wdata_i[`CTRL_T0_RUN];
                t1_run                <= reg_wdata_i[`CTRL_T1_RUN];
                ext_irq0_trigger_type <= reg_wdata_i[`CTRL_IRQ0_TRIG];
                ext_irq1_trigger_type <= reg_wdata_i[`CTRL_IRQ1_TRIG];
            end
            if (t0_ovf)
                t0_overflow_flag <= 1'b1;
            else if (t0_ack_i)
                t0_overflow_flag <= 1'b0;
            // split high byte owns timer 1 flag
            if (t0_split ? th0_ovf : t1_ovf)
                t1_overflow_flag <= 1'b1;
            else if (t1_ack_i)
                t1_overflow_flag <= 1'b0;
            // baud-rate style pulse from timer 1 even when split
            t1_overflow_pulse_o <= t1_ovf;
            if (irq0_hit)
                ext_irq0_flag <= 1'b1;
            else if (irq0_ack_i)
                ext_irq0_flag <= 1'b0;
            if (irq1_hit)
                ext_irq1_flag <= 1'b1;
            else if (irq1_ack_i)
                ext_irq1_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    // registered read data, zero for unmapped offsets
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            reg_rdata_o <= 8'h00;
        else
        begin
            case (reg_addr_i)
                `ADDR_CTRL:    reg_rdata_o <= {t1_overflow_flag, t1_run, t0_overflow_flag, t0_run,
                                               ext_irq1_flag, ext_irq1_trigger_type,
                                               ext_irq0_flag, ext_irq0_trigger_type};
                `ADDR_MODE:    reg_rdata_o <= timer_mode_register;
                `ADDR_T0_LOW:  reg_rdata_o <= t0_count_low;
                `ADDR_T0_HIGH: reg_rdata_o <= t0_count_high;
                `ADDR_T1_LOW:  reg_rdata_o <= t1_count_low;
                `ADDR_T1_HIGH: reg_rdata_o <= t1_count_high;
                default:       reg_rdata_o <= 8'h00;
            endcase
        end
    end

    assign t0_overflow_flag_o = t0_overflow_flag;
    assign t1_overflow_flag_o = t1_overflow_flag;
    assign ext_irq0_flag_o    = ext_irq0_flag;
    assign ext_irq1_flag_o    = ext_irq1_flag;

endmodule

// *** dv/ext_pin_model.sv ***
// ext_pin_model.sv
// far-side model: count pins and external interrupt pins of the dual timer
// assumes the bench calls its tasks; pins change only at falling clock edges
`timescale 1ns/1ps

module ext_pin_model
(
    input  wire sys_clk_i,
    output reg  t0_count_pin_o,
    output reg  t1_count_pin_o,
    output reg  ext_irq0_pin_o,
    output reg  ext_irq1_pin_o
);
    // pins idle high
    initial
    begin
        t0_count_pin_o = 1'b1;
        t1_count_pin_o = 1'b1;
        ext_irq0_pin_o = 1'b1;
        ext_irq1_pin_o = 1'b1;
    end

    // drive one interrupt pin level
    task set_irq(input int i, input bit v);
        @(negedge sys_clk_i);
        if (i == 0)
            ext_irq0_pin_o = v;
        else
            ext_irq1_pin_o = v;
    endtask

    task count_pulses(input int n);
        repeat (n)
        begin
            @(negedge sys_clk_i);
            t0_count_pin_o = 1'b0;
            repeat (24) @(negedge sys_clk_i);
            t0_count_pin_o = 1'b1;
            repeat (24) @(negedge sys_clk_i);
        end
    endtask
endmodule

// *** dv/dual_timer_counter_sva.sv ***
// dual_timer_counter_sva.sv
// port-level checker for the dual timer/counter
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/1ps

module dual_timer_counter_sva
(
    input wire       sys_clk_i,
    input wire       rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire       reg_wr_i,
    input wire [7:0] reg_rdata_o,
    input wire       ext_irq0_pin_i,
    input wire       t0_ack_i,
    input wire       t1_ack_i,
    input wire       irq0_ack_i,
    input wire       irq1_ack_i,
    input wire       t0_overflow_flag_o,
    input wire       t1_overflow_flag_o,
    input wire       ext_irq0_flag_o,
    input wire       ext_irq1_flag_o,
    input wire       t1_overflow_pulse_o
);
    reg [5:0] irq0_hist;

    // history of the irq0 pin level
    always @(posedge sys_clk_i or negedge rst_n_i)
        if (!rst_n_i)
            irq0_hist <= 6'h00;
        else
            irq0_hist <= {irq0_hist[4:0], ext_irq0_pin_i};

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_mode_readback: assert property (reg_wr_i && reg_addr_i == 8'h89 ##1 !reg_wr_i && reg_addr_i == 8'h89
        |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("mode register readback wrong");
    a_unmapped_zero: assert property ((reg_addr_i < 8'h88 || reg_addr_i > 8'h8d)
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_irq_rise_cause: assert property ($rose(ext_irq0_flag_o) |-> (!$past(ext_irq0_pin_i, 2)
        || !$past(ext_irq0_pin_i, 3) || !$past(ext_irq0_pin_i, 4) || !$past(ext_irq0_pin_i, 5)))
        else $error("irq0 flag set without low pin");
    a_pulse_single: assert property (t1_overflow_pulse_o |=> !t1_overflow_pulse_o)
        else $error("timer 1 pulse longer than one cycle");
    a_t0_flag_holds: assert property (t0_overflow_flag_o && !t0_ack_i |=> t0_overflow_flag_o)
        else $error("t0 flag lost without service");
    a_t1_flag_fall: assert property ($fell(t1_overflow_flag_o) |-> $past(t1_ack_i))
        else $error("t1 flag cleared without service");
    a_irq1_flag_holds: assert property (ext_irq1_flag_o && !irq1_ack_i |=> ext_irq1_flag_o)
        else $error("irq1 flag lost without service");
    a_irq0_ack_clear: assert property (irq0_ack_i && ext_irq0_pin_i && (&irq0_hist)
        |=> !ext_irq0_flag_o) else $error("irq0 flag not cleared by service");
    a_reset_quiet: assert property ($rose(rst_n_i) |-> reg_rdata_o == 8'h00 && !t0_overflow_flag_o
        && !t1_overflow_flag_o && !t1_overflow_pulse_o) else $error("outputs not quiet after reset");
endmodule

bind dual_timer_counter dual_timer_counter_sva u_sva
(
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rdata_o(reg_rdata_o), .ext_irq0_pin_i(ext_irq0_pin_i), .t0_ack_i(t0_ack_i),
    .t1_ack_i(t1_ack_i), .irq0_ack_i(irq0_ack_i), .irq1_ack_i(irq1_ack_i),
    .t0_overflow_flag_o(t0_overflow_flag_o), .t1_overflow_flag_o(t1_overflow_flag_o),
    .ext_irq0_flag_o(ext_irq0_flag_o), .ext_irq1_flag_o(ext_irq1_flag_o),
    .t1_overflow_pulse_o(t1_overflow_pulse_o)
);

// *** dv/tb_dual_timer_counter.sv ***
// tb_dual_timer_counter.sv
// self-checking bench: register tasks plus mode scenarios
// assumes the constants header is on the include path
`timescale 1ns/1ps
`include "dual_timer_consts.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end

module tb_dual_timer_counter;
    reg        sys_clk_i = 1'b0;
    reg        rst_n_i   = 1'b0;
    reg  [7:0] addr      = 8'h00;
    reg  [7:0] wdata     = 8'h00;
    reg        wr        = 1'b0;
    reg  [3:0] ack       = 4'h0;
    reg  [7:0] d;
    wire [7:0] rdata;
    wire [3:0] flags;
    wire       c0, c1, x0, x1, t1p;
    int        mismatches = 0, checks = 0, cycles = 0, n, t1p_cnt = 0;

    // ----------------------------------------
    // clock, instances
    // ----------------------------------------
    always #10 sys_clk_i = ~sys_clk_i;

    dual_timer_counter u_dual_timer_counter (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata), .t0_count_pin_i(c0), .t1_count_pin_i(c1),
        .ext_irq0_pin_i(x0), .ext_irq1_pin_i(x1), .t0_ack_i(ack[0]), .t1_ack_i(ack[1]), .irq0_ack_i(ack[2]),
        .irq1_ack_i(ack[3]), .t0_overflow_flag_o(flags[0]), .t1_overflow_flag_o(flags[1]),
        .ext_irq0_flag_o(flags[2]), .ext_irq1_flag_o(flags[3]), .t1_overflow_pulse_o(t1p));
    ext_pin_model u_ext_pin_model (.sys_clk_i(sys_clk_i), .t0_count_pin_o(c0), .t1_count_pin_o(c1),
        .ext_irq0_pin_o(x0), .ext_irq1_pin_o(x1));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task wr_reg(input [7:0] a, input [7:0] v);
        @(negedge sys_clk_i); addr = a; wdata = v; wr = 1'b1;
        @(negedge sys_clk_i); wr = 1'b0;
    endtask
    task rd_reg(input [7:0] a);
        @(negedge sys_clk_i); addr = a;
        @(negedge sys_clk_i); d = rdata;
    endtask
    task chk_reg(input [7:0] a, input [7:0] e);
        rd_reg(a);
        `CHK(d, e)
    endtask
    task wait_flag(input int i, input int lim);
        n = 0;
        while (flags[i] !== 1'b1 && n < lim)
        begin
            @(negedge sys_clk_i); n++;
        end
        `CHK(flags[i], 1'b1)
    endtask
    task ack_flag(input int i);
        @(negedge sys_clk_i); ack[i] = 1'b1;
        @(negedge sys_clk_i); ack[i] = 1'b0;
        `CHK(flags[i], 1'b0)
    endtask
    task run_for(input int c);
        repeat (c) @(negedge sys_clk_i);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // count timer 1 overflow pulses away from the launching edge
    always @(negedge sys_clk_i)
    begin
        if (t1p === 1'b1)
            t1p_cnt++;
    end

    // cycle ceiling against hangs
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            finish_test;
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        @(negedge sys_clk_i); rst_n_i = 1'b1;
        for (int a = 8'h87; a <= 8'h8e; a++) chk_reg(a[7:0], 8'h00);
        wr_reg(`ADDR_MODE, 8'ha5); chk_reg(`ADDR_MODE, 8'ha5);
        wr_reg(`ADDR_CTRL, 8'hff); chk_reg(`ADDR_CTRL, 8'h55);
        wr_reg(`ADDR_CTRL, 8'h00);
        $display("test registers done");
        wr_reg(`ADDR_T0_HIGH, 8'hff); wr_reg(`ADDR_T0_LOW, 8'hfe); wr_reg(`ADDR_MODE, 8'h01);
        wr_reg(`ADDR_CTRL, 8'h10); wait_flag(0, 40); `CHK(n > 11 && n < 27, 1'b1)
        wr_reg(`ADDR_CTRL, 8'h00); chk_reg(`ADDR_T0_HIGH, 8'h00); ack_flag(0);
        $display("test mode1 done");
        wr_reg(`ADDR_T0_HIGH, 8'hff); wr_reg(`ADDR_T0_LOW, 8'hff); wr_reg(`ADDR_MODE, 8'h00);
        wr_reg(`ADDR_CTRL, 8'h10); wait_flag(0, 14);
        wr_reg(`ADDR_CTRL, 8'h00); chk_reg(`ADDR_T0_HIGH, 8'h00); ack_flag(0);
        $display("test mode0 done");
        wr_reg(`ADDR_T0_HIGH, 8'hf0); wr_reg(`ADDR_T0_LOW, 8'hff); wr_reg(`ADDR_MODE, 8'h02);
        wr_reg(`ADDR_CTRL, 8'h10); wait_flag(0, 14); wr_reg(`ADDR_CTRL, 8'h00);
        chk_reg(`ADDR_T0_LOW, 8'hf0); chk_reg(`ADDR_T0_HIGH, 8'hf0); ack_flag(0);
        $display("test mode2 done");
        wr_reg(`ADDR_MODE, 8'h09); wr_reg(`ADDR_T0_HIGH, 8'h00); wr_reg(`ADDR_T0_LOW, 8'h00);
        u_ext_pin_model.set_irq(0, 1'b0); wr_reg(`ADDR_CTRL, 8'h10); run_for(60);
        `CHK(flags[2], 1'b1)
        wr_reg(`ADDR_CTRL, 8'h00); chk_reg(`ADDR_T0_LOW, 8'h00);
        u_ext_pin_model.set_irq(0, 1'b1); run_for(8); ack_flag(2);
        wr_reg(`ADDR_T0_LOW, 8'h40);
        wr_reg(`ADDR_CTRL, 8'h10); run_for(60); wr_reg(`ADDR_CTRL, 8'h00);
        rd_reg(`ADDR_T0_LOW); `CHK(d >= 8'h44 && d <= 8'h46, 1'b1)
        chk_reg(`ADDR_T0_HIGH, 8'h00);
        $display("test gate done");
        wr_reg(`ADDR_MODE, 8'h05); wr_reg(`ADDR_T0_LOW, 8'h00); wr_reg(`ADDR_CTRL, 8'h10);
        u_ext_pin_model.count_pulses(3); run_for(40); wr_reg(`ADDR_CTRL, 8'h00);
        chk_reg(`ADDR_T0_LOW, 8'h03);
        $display("test counter done");
        wr_reg(`ADDR_MODE, 8'h30); wr_reg(`ADDR_T1_HIGH, 8'hfd); wr_reg(`ADDR_T1_LOW, 8'hfe);
        wr_reg(`ADDR_CTRL, 8'h40); run_for(60); chk_reg(`ADDR_T1_LOW, 8'hfe);
        wr_reg(`ADDR_MODE, 8'h20); wait_flag(1, 40); wr_reg(`ADDR_CTRL, 8'h00); ack_flag(1);
        `CHK(t1p_cnt, 1)
        $display("test timer1 done");
        wr_reg(`ADDR_MODE, 8'h03); wr_reg(`ADDR_T0_HIGH, 8'hff); wr_reg(`ADDR_T0_LOW, 8'h00);
        wr_reg(`ADDR_CTRL, 8'h40); wait_flag(1, 14); wr_reg(`ADDR_CTRL, 8'h00);
        chk_reg(`ADDR_T0_LOW, 8'h00); ack_flag(1);
        wr_reg(`ADDR_T0_HIGH, 8'hff); wr_reg(`ADDR_T0_LOW, 8'hff); wr_reg(`ADDR_CTRL, 8'h50);
        wait_flag(0, 14); wait_flag(1, 14); wr_reg(`ADDR_CTRL, 8'h00);
        ack_flag(0); ack_flag(1);
        $display("test split done");
        wr_reg(`ADDR_CTRL, 8'h04); u_ext_pin_model.set_irq(1, 1'b0); wait_flag(3, 8);
        ack_flag(3); run_for(8); `CHK(flags[3], 1'b0)
        u_ext_pin_model.set_irq(1, 1'b1);
        $display("test edge done");
        finish_test;
    end
endmodule
